// ===== rtl/wwds_pkg.sv
// constants, types and timing of the window watchdog and wake supervisor
// assumes a single 50 MHz system clock; all pins arrive asynchronously
package wwds_pkg;

	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned TRIG_MIN_NS    = 3000;
	localparam int unsigned RESET_HOLD_NS  = 10000000;
	localparam int unsigned OSC_SHORT_NS   = 4000000;
	localparam int unsigned OSC_OPEN_NS    = 7000000;
	localparam int unsigned OSC_PERIOD_NS  = 12500;
	localparam int unsigned WAKE_FILT_NS   = 50000;

	localparam int unsigned TRIG_MIN_CYC   = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_NS / CLK_PERIOD_NS;
	localparam int unsigned OSC_SHORT_CYC  = OSC_SHORT_NS / CLK_PERIOD_NS;
	localparam int unsigned OSC_OPEN_CYC   = OSC_OPEN_NS / CLK_PERIOD_NS;
	localparam int unsigned OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned WAKE_FILT_CYC  = WAKE_FILT_NS / CLK_PERIOD_NS;

	localparam int unsigned CYC_W  = 20;
	localparam int unsigned TICK_W = 12;

	localparam logic [TICK_W-1:0] LEAD_TICKS   = 12'hf52;
	localparam logic [TICK_W-1:0] CLOSED_TICKS = 12'h320;
	localparam logic [TICK_W-1:0] OPEN_TICKS   = 12'h348;
	localparam logic [TICK_W-1:0] NRES_TICKS   = 12'h09d;

	typedef enum logic [1:0] {
		MODE_PRENORM,
		MODE_NORMAL,
		MODE_SILENT,
		MODE_SLEEP
	} wwds_mode_t;

	typedef enum logic [2:0] {
		WD_OFF,
		WD_LEAD,
		WD_CLOSED,
		WD_OPEN,
		WD_RESET
	} wwds_wd_t;

	typedef struct packed {
		logic bus_remote;
		logic pin_local;
		logic bus_weak;
	} wwds_wake_t;

endpackage : wwds_pkg

// ===== rtl/wwds_supervisor.sv
// window watchdog, operating mode control and wake-up indication
// assumes filtered analog wake and supply detectors; pins are asynchronous
`timescale 1ns/1ps
module wwds_supervisor #(
	parameter int unsigned OSC_PERIOD_CYC = wwds_pkg::OSC_PERIOD_CYC,
	parameter int unsigned RESET_HOLD_CYC = wwds_pkg::RESET_HOLD_CYC,
	parameter int unsigned OSC_SHORT_CYC  = wwds_pkg::OSC_SHORT_CYC,
	parameter int unsigned OSC_OPEN_CYC   = wwds_pkg::OSC_OPEN_CYC,
	parameter int unsigned WAKE_FILT_CYC  = wwds_pkg::WAKE_FILT_CYC,
	parameter int unsigned TRIG_MIN_CYC   = wwds_pkg::TRIG_MIN_CYC
) (
	// clock and reset
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_in,
	// controller pins
	input  wire logic                 en_in,
	input  wire logic                 txd_in,
	input  wire logic                 rising_trigger_in,
	input  wire logic                 falling_trigger_in,
	input  wire logic                 debug_mode_in,
	// analog detectors
	input  wire wwds_pkg::wwds_wake_t wake_in,
	input  wire logic                 vcc_undervolt_in,
	input  wire logic                 osc_resistor_pin_short_in,
	input  wire logic                 osc_resistor_pin_open_in,
	// outputs to controller
	output logic                      reset_n_out,
	output logic                      rxd_out,
	output logic                      txd_out,
	output logic                      txd_oe_out,
	output wwds_pkg::wwds_mode_t      mode_out
);

	localparam int unsigned CW = wwds_pkg::CYC_W;
	localparam int unsigned TW = wwds_pkg::TICK_W;
	localparam int unsigned NS = 11;
	localparam logic [NS-1:0] SYNC_IDLE = 11'h080; // idle pin levels, falling trigger high

	// two-stage synchronisers
	logic [NS-1:0] sync1_reg;
	logic [NS-1:0] sync2_reg;
	logic          en_s;
	logic          txd_s;
	logic          dbg_s;
	logic          uv_s;
	logic          short_s;
	logic          open_s;
	logic [1:0]    trig_s;
	wwds_pkg::wwds_wake_t wake_s;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sync1_reg <= SYNC_IDLE;
			sync2_reg <= SYNC_IDLE;
		end else begin
			sync1_reg <= {en_in, txd_in, rising_trigger_in, falling_trigger_in, debug_mode_in,
				vcc_undervolt_in, osc_resistor_pin_short_in, osc_resistor_pin_open_in, wake_in};
			sync2_reg <= sync1_reg;
		end
	end

	assign {en_s, txd_s, trig_s, dbg_s, uv_s, short_s, open_s, wake_s} = sync2_reg;

	// enable edges
	logic en_prev_reg;
	logic en_rise;
	logic en_fall;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			en_prev_reg <= 1'h0;
		end else begin
			en_prev_reg <= en_s;
		end
	end

	assign en_rise = en_s & ~en_prev_reg;
	assign en_fall = ~en_s & en_prev_reg;

	// trigger pulse qualification, bit 1 rising input, bit 0 falling input
	logic [1:0] trig_act;
	logic [1:0] trig_hit;
	logic       trig_evt;

	assign trig_act = {trig_s[1], ~trig_s[0]};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_trig
			logic [CW-1:0] width_reg;
			always_ff @(posedge sys_clk_in) begin
				if (rst_in || !trig_act[gi]) begin
					width_reg <= '0;
				end else if (width_reg <= CW'(TRIG_MIN_CYC)) begin
					width_reg <= width_reg + CW'(1);
				end
			end
			// one event per pulse once it is longer than the minimum
			assign trig_hit[gi] = trig_act[gi] && width_reg == CW'(TRIG_MIN_CYC);
		end
	endgenerate

	assign trig_evt = |trig_hit;

	// local wake filter for wake pin and weak bus drop
	logic [CW-1:0] wake_filt_reg;
	logic          local_evt;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !(wake_s.pin_local || wake_s.bus_weak)) begin
			wake_filt_reg <= '0;
		end else if (wake_filt_reg < CW'(WAKE_FILT_CYC)) begin
			wake_filt_reg <= wake_filt_reg + CW'(1);
		end
	end

	assign local_evt = (wake_s.pin_local || wake_s.bus_weak)
		&& wake_filt_reg == CW'(WAKE_FILT_CYC - 1);

	// operating mode
	wwds_pkg::wwds_mode_t mode_reg;
	logic                 asleep;
	logic                 wake_evt;
	logic [CW-1:0]        por_cnt_reg;
	logic                 por_hold;

	assign asleep   = mode_reg == wwds_pkg::MODE_SILENT || mode_reg == wwds_pkg::MODE_SLEEP;
	assign wake_evt = asleep && (wake_s.bus_remote || local_evt);
	assign por_hold = por_cnt_reg != '0;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			mode_reg <= wwds_pkg::MODE_PRENORM;
		end else if (uv_s) begin
			mode_reg <= wwds_pkg::MODE_PRENORM;
		end else begin
			case (mode_reg)
				wwds_pkg::MODE_PRENORM: begin
					if (en_rise && !por_hold) begin
						mode_reg <= wwds_pkg::MODE_NORMAL;
					end
				end
				wwds_pkg::MODE_NORMAL: begin
					if (en_fall) begin
						mode_reg <= txd_s ? wwds_pkg::MODE_SILENT : wwds_pkg::MODE_SLEEP;
					end
				end
				wwds_pkg::MODE_SILENT: begin
					if (en_s) begin
						mode_reg <= wwds_pkg::MODE_NORMAL;
					end else if (wake_evt) begin
						mode_reg <= wwds_pkg::MODE_PRENORM;
					end
				end
				wwds_pkg::MODE_SLEEP: begin
					if (wake_evt) begin
						mode_reg <= wwds_pkg::MODE_PRENORM;
					end
				end
				default: begin
					mode_reg <= wwds_pkg::MODE_PRENORM;
				end
			endcase
		end
	end

	// supply reset hold after power-up, undervoltage or sleep wake
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			por_cnt_reg <= CW'(RESET_HOLD_CYC);
		end else if (uv_s) begin
			por_cnt_reg <= CW'(RESET_HOLD_CYC);
		end else if (mode_reg == wwds_pkg::MODE_SLEEP && wake_evt) begin
			por_cnt_reg <= CW'(RESET_HOLD_CYC);
		end else if (por_hold) begin
			por_cnt_reg <= por_cnt_reg - CW'(1);
		end
	end

	// wake request and source flags, a new wake beats the clear
	logic wake_req_reg;
	logic wake_remote_reg;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			wake_req_reg    <= 1'h0;
			wake_remote_reg <= 1'h0;
		end else if (wake_evt) begin
			wake_req_reg    <= 1'h1;
			wake_remote_reg <= wake_s.bus_remote;
		end else if (en_rise) begin
			wake_req_reg    <= 1'h0;
			wake_remote_reg <= 1'h0;
		end
	end

	// watchdog oscillator and resistor fault timer
	logic          wd_en;
	logic [CW-1:0] div_cnt_reg;
	logic          tick;
	logic [CW-1:0] fault_cnt_reg;
	logic          fault_fire;

	assign wd_en = (mode_reg == wwds_pkg::MODE_PRENORM || mode_reg == wwds_pkg::MODE_NORMAL)
		&& !dbg_s && !por_hold && !uv_s;
	assign tick  = wd_en && div_cnt_reg == CW'(OSC_PERIOD_CYC - 1);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !wd_en || tick) begin
			div_cnt_reg <= '0;
		end else begin
			div_cnt_reg <= div_cnt_reg + CW'(1);
		end
	end

	assign fault_fire = wd_en && ((short_s && fault_cnt_reg == CW'(OSC_SHORT_CYC - 1))
		|| (open_s && fault_cnt_reg == CW'(OSC_OPEN_CYC - 1)));

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !wd_en || !(short_s || open_s) || fault_fire) begin
			fault_cnt_reg <= '0;
		end else begin
			fault_cnt_reg <= fault_cnt_reg + CW'(1);
		end
	end

	// window sequence on one shared period counter
	wwds_pkg::wwds_wd_t wd_reg;
	logic [TW-1:0]      per_reg;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !wd_en) begin
			wd_reg  <= wwds_pkg::WD_OFF;
			per_reg <= '0;
		end else if (fault_fire && wd_reg != wwds_pkg::WD_RESET) begin
			wd_reg  <= wwds_pkg::WD_RESET;
			per_reg <= '0;
		end else begin
			case (wd_reg)
				wwds_pkg::WD_OFF: begin
					wd_reg  <= wwds_pkg::WD_LEAD;
					per_reg <= '0;
				end
				wwds_pkg::WD_LEAD: begin
					if (trig_evt) begin
						wd_reg  <= wwds_pkg::WD_CLOSED;
						per_reg <= '0;
					end else if (tick && per_reg == wwds_pkg::LEAD_TICKS - 12'h001) begin
						wd_reg  <= wwds_pkg::WD_RESET;
						per_reg <= '0;
					end else if (tick) begin
						per_reg <= per_reg + 12'h001;
					end
				end
				wwds_pkg::WD_CLOSED: begin
					if (trig_evt) begin
						wd_reg  <= wwds_pkg::WD_RESET;
						per_reg <= '0;
					end else if (tick && per_reg == wwds_pkg::CLOSED_TICKS - 12'h001) begin
						wd_reg  <= wwds_pkg::WD_OPEN;
						per_reg <= '0;
					end else if (tick) begin
						per_reg <= per_reg + 12'h001;
					end
				end
				wwds_pkg::WD_OPEN: begin
					if (trig_evt) begin
						wd_reg  <= wwds_pkg::WD_CLOSED;
						per_reg <= '0;
					end else if (tick && per_reg == wwds_pkg::OPEN_TICKS - 12'h001) begin
						wd_reg  <= wwds_pkg::WD_RESET;
						per_reg <= '0;
					end else if (tick) begin
						per_reg <= per_reg + 12'h001;
					end
				end
				wwds_pkg::WD_RESET: begin
					if (tick && per_reg == wwds_pkg::NRES_TICKS - 12'h001) begin
						wd_reg  <= wwds_pkg::WD_LEAD;
						per_reg <= '0;
					end else if (tick) begin
						per_reg <= per_reg + 12'h001;
					end
				end
				default: begin
					wd_reg  <= wwds_pkg::WD_OFF;
					per_reg <= '0;
				end
			endcase
		end
	end

	// registered pin outputs
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			reset_n_out <= 1'h0;
			rxd_out     <= 1'h0;
			txd_out     <= 1'h0;
			txd_oe_out  <= 1'h0;
			mode_out    <= wwds_pkg::MODE_PRENORM;
		end else begin
			reset_n_out <= !(por_hold || uv_s || mode_reg == wwds_pkg::MODE_SLEEP
				|| wd_reg == wwds_pkg::WD_RESET);
			rxd_out     <= mode_reg != wwds_pkg::MODE_SLEEP && !wake_req_reg;
			txd_out     <= wake_remote_reg;
			txd_oe_out  <= mode_reg == wwds_pkg::MODE_PRENORM;
			mode_out    <= mode_reg;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_closed_hit;
		wd_reg == wwds_pkg::WD_CLOSED && trig_evt && wd_en && !fault_fire;
	endsequence

	a_closed_trig_reset: assert property (s_closed_hit ##1 wd_en |->
		wd_reg == wwds_pkg::WD_RESET ##1 !reset_n_out)
		else $error("closed window trigger did not reset");

	a_lead_trig_closed: assert property (wd_reg == wwds_pkg::WD_LEAD && trig_evt
		&& wd_en && !fault_fire ##1 wd_en |-> wd_reg == wwds_pkg::WD_CLOSED && per_reg == '0)
		else $error("lead trigger did not open closed window");

	a_open_trig_restart: assert property (wd_reg == wwds_pkg::WD_OPEN && trig_evt
		&& wd_en && !fault_fire ##1 wd_en |-> wd_reg == wwds_pkg::WD_CLOSED)
		else $error("open window trigger did not restart");

	a_open_expiry_reset: assert property (wd_reg == wwds_pkg::WD_OPEN && !trig_evt
		&& tick && per_reg == 12'h347 ##1 wd_en |-> wd_reg == wwds_pkg::WD_RESET)
		else $error("open window expiry missed");

	a_lead_expiry_reset: assert property (wd_reg == wwds_pkg::WD_LEAD && !trig_evt
		&& tick && per_reg == 12'hf51 ##1 wd_en |-> wd_reg == wwds_pkg::WD_RESET)
		else $error("lead expiry missed");

	a_closed_to_open: assert property (wd_reg == wwds_pkg::WD_CLOSED && !trig_evt
		&& !fault_fire && tick && per_reg == 12'h31f ##1 wd_en |-> wd_reg == wwds_pkg::WD_OPEN)
		else $error("closed window length wrong");

	a_reset_len_lead: assert property (wd_reg == wwds_pkg::WD_RESET && tick
		&& per_reg == 12'h09c ##1 wd_en |-> wd_reg == wwds_pkg::WD_LEAD)
		else $error("watchdog reset length wrong");

	a_reset_drives_pin: assert property (wd_reg == wwds_pkg::WD_RESET |=> !reset_n_out)
		else $error("watchdog reset not on pin");

	a_asleep_wd_off: assert property (asleep ##1 asleep |-> wd_reg == wwds_pkg::WD_OFF
		&& div_cnt_reg == '0)
		else $error("watchdog running while asleep");

	a_debug_wd_off: assert property (dbg_s ##1 dbg_s |-> wd_reg == wwds_pkg::WD_OFF)
		else $error("watchdog running in debug");

	a_en_clears_flags: assert property (en_rise && !wake_evt |=>
		!wake_req_reg && !wake_remote_reg)
		else $error("enable did not clear wake flags");

	a_prenorm_txd_out: assert property (mode_reg == wwds_pkg::MODE_PRENORM |=>
		txd_oe_out && txd_out == $past(wake_remote_reg))
		else $error("txd not driven in pre-normal");

	a_uv_prenorm: assert property (uv_s |=> mode_reg == wwds_pkg::MODE_PRENORM
		##1 !reset_n_out)
		else $error("undervoltage not handled");

	a_trig_min_width: assert property (trig_evt |->
		(trig_hit[0] && $past(trig_act[0], TRIG_MIN_CYC))
		|| (trig_hit[1] && $past(trig_act[1], TRIG_MIN_CYC)))
		else $error("trigger accepted too short");

endmodule : wwds_supervisor

// ===== test/tb_top.sv
// self-checking bench of the window watchdog and wake supervisor
// assumes shortened timing parameters; trigger, enable and txd pins come from the model, debug from the bench
`timescale 1ns/1ps
module tb_top;
	typedef struct {
		logic rise;
		int   len;
		int   gap;
		logic rst_n;
	} wwds_row_t;

	localparam int OSC   = 2;
	localparam int HOLD  = 50;
	localparam int SHORT = 40;
	localparam int OPEN  = 70;
	localparam int LEAD  = 3922 * OSC;
	localparam int WIN   = 800 * OSC + 840 * OSC;
	localparam int NRES  = 157 * OSC;

	logic                 sys_clk   = 1'h0;
	logic                 rst       = 1'h1;
	logic                 debug     = 1'h0;
	logic                 vcc_uv    = 1'h0;
	logic                 osc_short = 1'h0;
	logic                 osc_open  = 1'h0;
	wwds_pkg::wwds_wake_t wake      = '0;
	logic                 en;
	logic                 txd;
	logic                 rtrig;
	logic                 ftrig;
	logic                 reset_n;
	logic                 rxd;
	logic                 txd_o;
	logic                 txd_oe;
	wwds_pkg::wwds_mode_t mode;
	int                   failures  = 0;
	int                   checked   = 0;
	int                   n;
	// lead, open, glitch in closed, open, closed
	wwds_row_t rows[5] = '{'{1'h0, 8, 100, 1'h1}, '{1'h1, 8, 2000, 1'h1},
		'{1'h0, 3, 500, 1'h1}, '{1'h1, 8, 1800, 1'h1}, '{1'h0, 8, 400, 1'h0}};

	always #10 sys_clk = ~sys_clk;

	wwds_uc_model uc (
		.clk_in              (sys_clk),
		.rising_trigger_out  (rtrig),
		.falling_trigger_out (ftrig),
		.en_out              (en),
		.txd_out             (txd)
	);

	wwds_supervisor #(.OSC_PERIOD_CYC(OSC), .RESET_HOLD_CYC(HOLD), .OSC_SHORT_CYC(SHORT),
		.OSC_OPEN_CYC(OPEN), .WAKE_FILT_CYC(10), .TRIG_MIN_CYC(4)) dut (
		.sys_clk_in                (sys_clk),
		.rst_in                    (rst),
		.en_in                     (en),
		.txd_in                    (txd),
		.rising_trigger_in         (rtrig),
		.falling_trigger_in        (ftrig),
		.debug_mode_in             (debug),
		.wake_in                   (wake),
		.vcc_undervolt_in          (vcc_uv),
		.osc_resistor_pin_short_in (osc_short),
		.osc_resistor_pin_open_in  (osc_open),
		.reset_n_out               (reset_n),
		.rxd_out                   (rxd),
		.txd_out                   (txd_o),
		.txd_oe_out                (txd_oe),
		.mode_out                  (mode)
	);

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : cyc

	task automatic bad(input string m);
		failures++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : bad

	task automatic chk_bit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp)
			bad(m);
	endtask : chk_bit

	task automatic chk_mode(input wwds_pkg::wwds_mode_t got, input wwds_pkg::wwds_mode_t exp,
		input string m);
		checked++;
		if (got !== exp)
			bad(m);
	endtask : chk_mode

	task automatic chk_cnt(input int got, input int lo, input int hi, input string m);
		checked++;
		if (got < lo || got > hi)
			bad(m);
	endtask : chk_cnt

	// cycles until the reset output reaches lvl, bounded
	task automatic wait_rst(input logic lvl, output int k);
		k = 0;
		while (reset_n !== lvl && k < 20000) begin
			@(negedge sys_clk);
			k++;
		end
	endtask : wait_rst

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	initial begin
		#1600000;
		bad("watchdog timeout");
		stop_test();
	end

	initial begin
		cyc(5);
		chk_bit(reset_n, 1'h0, "reset output in reset");
		chk_mode(mode, wwds_pkg::MODE_PRENORM, "mode in reset");
		cyc(5);
		rst = 1'h0;
		wait_rst(1'h1, n);
		chk_cnt(n, HOLD - 2, HOLD + 6, "power-up hold");
		wait_rst(1'h0, n);
		chk_cnt(n, LEAD - 8, LEAD + 8, "lead time");
		wait_rst(1'h1, n);
		chk_cnt(n, NRES - 4, NRES + 4, "reset width");
		$display("test reset and lead done");
		foreach (rows[i]) begin
			cyc(rows[i].gap);
			uc.pulse(rows[i].rise, rows[i].len);
			cyc(20);
			chk_bit(reset_n, rows[i].rst_n, "trigger row");
		end
		wait_rst(1'h1, n);
		$display("test trigger table done");
		uc.pulse(1'h0, 8);
		wait_rst(1'h0, n);
		chk_cnt(n, WIN - 10, WIN + 15, "open window expiry");
		wait_rst(1'h1, n);
		osc_short = 1'h1;
		wait_rst(1'h0, n);
		osc_short = 1'h0;
		chk_cnt(n, SHORT - 2, SHORT + 10, "resistor short");
		wait_rst(1'h1, n);
		osc_open = 1'h1;
		wait_rst(1'h0, n);
		osc_open = 1'h0;
		chk_cnt(n, OPEN - 2, OPEN + 10, "resistor open");
		wait_rst(1'h1, n);
		debug = 1'h1;
		cyc(LEAD + 200);
		chk_bit(reset_n, 1'h1, "debug select");
		debug = 1'h0;
		$display("test faults and debug done");
		uc.set_pins(1'h1, 1'h1);
		cyc(8);
		chk_mode(mode, wwds_pkg::MODE_NORMAL, "normal mode");
		chk_bit(txd_oe, 1'h0, "txd released");
		uc.set_pins(1'h0, 1'h1);
		cyc(LEAD + 1000);
		chk_mode(mode, wwds_pkg::MODE_SILENT, "silent mode");
		chk_bit(reset_n, 1'h1, "silent watchdog off");
		wake.bus_remote = 1'h1;
		cyc(4);
		wake = '0;
		cyc(6);
		chk_mode(mode, wwds_pkg::MODE_PRENORM, "remote wake");
		chk_bit(rxd, 1'h0, "wake request");
		chk_bit(txd_o, 1'h1, "remote source");
		chk_bit(txd_oe, 1'h1, "txd driven");
		uc.set_pins(1'h1, 1'h1);
		cyc(6);
		chk_bit(rxd, 1'h1, "request cleared");
		chk_bit(txd_o, 1'h0, "source cleared");
		wait_rst(1'h0, n);
		chk_cnt(n, LEAD - 25, LEAD - 5, "lead after silent wake");
		wait_rst(1'h1, n);
		for (int s = 0; s < 2; s++) begin
			uc.set_pins(1'h0, 1'h1);
			cyc(8);
			wake = s ? 3'h1 : 3'h2;
			cyc(5);
			wake = '0;
			cyc(8);
			chk_mode(mode, wwds_pkg::MODE_SILENT, "short wake filtered");
			wake = s ? 3'h1 : 3'h2;
			cyc(30);
			wake = '0;
			chk_mode(mode, wwds_pkg::MODE_PRENORM, "local wake");
			chk_bit(rxd, 1'h0, "local request");
			chk_bit(txd_o, 1'h0, "local source");
			uc.set_pins(1'h1, 1'h1);
			cyc(8);
		end
		uc.set_pins(1'h0, 1'h0);
		cyc(8);
		chk_mode(mode, wwds_pkg::MODE_SLEEP, "sleep mode");
		chk_bit(rxd, 1'h0, "rxd in sleep");
		wake.bus_remote = 1'h1;
		cyc(4);
		wake = '0;
		wait_rst(1'h1, n);
		chk_cnt(n, HOLD - 6, HOLD + 6, "sleep wake hold");
		uc.set_pins(1'h1, 1'h1);
		cyc(8);
		vcc_uv = 1'h1;
		cyc(6);
		chk_bit(reset_n, 1'h0, "undervoltage reset");
		chk_mode(mode, wwds_pkg::MODE_PRENORM, "undervoltage mode");
		vcc_uv = 1'h0;
		wait_rst(1'h1, n);
		chk_cnt(n, HOLD - 6, HOLD + 6, "undervoltage hold");
		$display("test modes and wake done");
		stop_test();
	end
endmodule : tb_top

// ===== test/wwds_uc_model.sv
// controller model driving trigger, enable and txd pins
// assumes the bench calls its tasks; pins change on falling clock edges
`timescale 1ns/1ps
module wwds_uc_model (
	// clock
	input  wire logic clk_in,
	// pins to the supervisor
	output logic      rising_trigger_out,
	output logic      falling_trigger_out,
	output logic      en_out,
	output logic      txd_out
);
	initial begin
		rising_trigger_out  = 1'h0;
		falling_trigger_out = 1'h1;
		en_out              = 1'h0;
		txd_out             = 1'h1;
	end

	// one trigger pulse; short lengths only where a glitch is meant
	task automatic pulse(input logic rise, input int len);
		@(negedge clk_in);
		if (rise)
			rising_trigger_out = 1'h1;
		else
			falling_trigger_out = 1'h0;
		repeat (len) @(negedge clk_in);
		rising_trigger_out  = 1'h0;
		falling_trigger_out = 1'h1;
	endtask : pulse

	// txd settles a cycle before the enable edge selects the mode
	task automatic set_pins(input logic en, input logic txd);
		@(negedge clk_in);
		txd_out = txd;
		@(negedge clk_in);
		en_out = en;
	endtask : set_pins
endmodule : wwds_uc_model
